// *** counter_remote_settings.v ***
// Purpose : Remote settings and legacy output format of a frequency counter
// Assumes : Command parser writes settings over AXI4-Lite; measurement core
//           supplies results on plain ports in the same clock domain
// Notes   : Overview of operation list below; codes match the query encoding
//
// Overview of operation
// - Auto-update copies each result into offset
// - Host-written offset clamped to zero..Fmax
// - Style 0: talk returns newest result record
// - Style 1: measure only after result delivered
// - Any program message forces output style 2
// - Record kind character F, R, W, P
// - Offset flag S/space; sign minus/space
// - Twelve digits, point, exponent E+0..E+9
// - Line ending 0 LF, 1 CR LF
// - Timebase 0 auto, 1 internal reference
// - Granularity code 0..9, default 5
// - Hold stops measuring; trigger restarts
// - Pause code 1-2-5 from 1 ms, default 6
// - Aggregate function 0..4, default off
// - Count exponent 1..6; ten or two power
// - Trigger source internal, pin, mains
// - Trigger delay rounded down to steps
// - Trigger polarity 0 rising, 1 falling
// - Fast sampling starts only on trigger
// - Base frequency reads zero on channel two
// - Fast points 100, 200, 500, 1000, 2000 only, default 2000
// - Fast interval 10..1000 us, 1-2-5 rounding
`timescale 1ns/1ps
`include "counter_remote_settings_map.vh"

module counter_remote_settings (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  // AXI4-Lite write address and data
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  // AXI4-Lite write response
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  // AXI4-Lite read
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  // Measurement core, same clock
  input  wire        i_result_valid,
  input  wire [39:0] i_result_value,
  input  wire        i_result_negative,
  input  wire [1:0]  i_result_kind,
  input  wire [1:0]  i_result_exp,
  input  wire [39:0] i_base_freq,
  input  wire        i_channel_two,
  // Settings toward the measurement core
  output reg         o_measure_enable,
  output reg         o_fast_start,
  output reg         o_internal_ref,
  output reg  [3:0]  o_granularity,
  output reg  [3:0]  o_pause_code,
  output reg  [2:0]  o_aggregate_function,
  output reg  [20:0] o_aggregate_count,
  output reg  [1:0]  o_trigger_source,
  output reg         o_trigger_polarity,
  output reg  [26:0] o_trigger_delay,
  output reg  [39:0] o_offset_frequency,
  output reg         o_crlf_ending
);

  // ----------------------------------------------------------------
  // Setting registers
  // ----------------------------------------------------------------
  reg        offset_auto_update_r;
  reg        offset_active_r;
  reg [1:0]  output_style_r;
  reg        line_ending_select_r;
  reg        sample_or_freeze_r;
  reg        aggregate_overlap_select_r;
  reg [2:0]  aggregate_count_exponent_r;
  reg        fast_sampling_enable_r;
  reg [11:0] fast_sampling_points_r;
  reg [10:0] fast_sampling_interval_r;
  reg        pending_r;
  reg [39:0] latest_value_r;
  reg        latest_neg_r;
  reg [1:0]  latest_kind_r;
  reg [1:0]  latest_exp_r;

  // Bus holding registers
  reg [7:0]  aw_addr_r;
  reg        aw_have_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  reg        w_have_r;

  // ----------------------------------------------------------------
  // Rounding, point check and count helpers
  // ----------------------------------------------------------------
  // Round delay down to allowed step
  function [26:0] round_delay;
    input [26:0] ns;
    reg   [26:0] q;
    reg   [26:0] scale;
    begin
      q = ns;
      scale = 27'h1;
      if (ns < (`DLY_OFF_NS << 1)) begin
        round_delay = 27'h0;
      end else if (ns <= `DLY_STEP1_MAX) begin
        round_delay = ns - (ns % 27'h14);
      end else if (ns < `DLY_STEP2_MAX) begin
        round_delay = ns - (ns % 27'h28);
      end else begin
        if (ns > `DLY_MAX_NS) q = `DLY_MAX_NS;
        while (q >= 27'h64) begin
          q = q / 27'hA;
          scale = scale * 27'hA;
        end
        round_delay = q * scale;
      end
    end
  endfunction

  // Round interval to nearest 1-2-5 step
  function [10:0] round_interval;
    input [31:0] us;
    begin
      if (us < 32'h0F) round_interval = 11'h00A;
      else if (us < 32'h23) round_interval = 11'h014;
      else if (us < 32'h4B) round_interval = 11'h032;
      else if (us < 32'h96) round_interval = 11'h064;
      else if (us < 32'h15E) round_interval = 11'h0C8;
      else if (us < 32'h2EE) round_interval = 11'h1F4;
      else round_interval = 11'h3E8;
    end
  endfunction

  // Accept only listed point counts
  function valid_points;
    input [31:0] n;
    begin
      valid_points = (n == 32'h64) || (n == 32'hC8) || (n == 32'h1F4) ||
                     (n == 32'h3E8) || (n == 32'h7D0);
    end
  endfunction

  // Sample count from exponent and overlap select
  function [20:0] agg_count;
    input       overlap;
    input [2:0] e;
    begin
      if (overlap) begin
        agg_count = 21'h1 << e;
      end else begin
        case (e)
          3'h1: agg_count = 21'h0_000A;
          3'h2: agg_count = 21'h0_0064;
          3'h3: agg_count = 21'h0_03E8;
          3'h4: agg_count = 21'h0_2710;
          3'h5: agg_count = 21'h1_86A0;
          default: agg_count = 21'hF_4240;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------------------------------
  wire aw_take = i_awvalid & o_awready;
  wire w_take  = i_wvalid & o_wready;
  wire do_write = aw_have_r & w_have_r & ~o_bvalid;
  wire [31:0] wd = w_data_r;

  // Capture address and data in either order
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      o_awready <= ~aw_have_r & ~aw_take & ~o_bvalid;
      o_wready  <= ~w_have_r & ~w_take & ~o_bvalid;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= (aw_addr_r > `OFS_EVENT || aw_addr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Legacy record assembly
  // ----------------------------------------------------------------
  reg [7:0] kind_char;
  always @* begin
    case (latest_kind_r)
      2'h0: kind_char = `CH_ASCII_F;
      2'h1: kind_char = `CH_ASCII_R;
      2'h2: kind_char = `CH_ASCII_W;
      default: kind_char = `CH_ASCII_P;
    endcase
  end
  wire [7:0] record_kind_field  = kind_char;
  wire [7:0] record_offset_flag = offset_active_r ? `CH_ASCII_S : `CH_ASCII_SP;
  wire [7:0] record_sign_field  = latest_neg_r ? `CH_ASCII_MINUS : `CH_ASCII_SP;
  // Exponent index 0..3 stands for E+0, E+3, E+6, E+9
  wire [7:0] record_exponent    = {6'h0C, latest_exp_r};
  wire [7:0] record_terminator  = line_ending_select_r ? `CH_ASCII_CR : `CH_ASCII_LF;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire ar_take = i_arvalid & o_arready;
  reg [31:0] rd_mux;
  reg        rd_err;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (i_araddr)
      `OFS_CTRL:        rd_mux = {21'h0, pending_r, offset_auto_update_r, offset_active_r,
                                  aggregate_overlap_select_r, fast_sampling_enable_r,
                                  o_trigger_polarity, sample_or_freeze_r, o_internal_ref,
                                  line_ending_select_r, output_style_r};
      `OFS_OFFSET_LO:   rd_mux = o_offset_frequency[31:0];
      `OFS_OFFSET_HI:   rd_mux = {24'h0, o_offset_frequency[39:32]};
      `OFS_MEAS:        rd_mux = {16'h0, 1'b0, aggregate_count_exponent_r, 1'b0,
                                  o_aggregate_function, o_pause_code, o_granularity};
      `OFS_TRIG:        rd_mux = {30'h0, o_trigger_source};
      `OFS_DELAY:       rd_mux = {5'h0, o_trigger_delay};
      `OFS_FAST:        rd_mux = {5'h0, fast_sampling_interval_r, 4'h0, fast_sampling_points_r};
      `OFS_STATUS:      rd_mux = {29'h0, o_measure_enable, offset_auto_update_r, pending_r};
      `OFS_RESULT_LO:   rd_mux = latest_value_r[31:0];
      `OFS_RESULT_HI:   rd_mux = {24'h0, latest_value_r[39:32]};
      `OFS_RECORD:      rd_mux = {record_kind_field, record_offset_flag,
                                  record_sign_field, record_exponent};
      `OFS_BASEFREQ_LO: rd_mux = i_channel_two ? 32'h0 : i_base_freq[31:0];
      `OFS_BASEFREQ_HI: rd_mux = i_channel_two ? 32'h0 : {24'h0, i_base_freq[39:32]};
      `OFS_EVENT:       rd_mux = {24'h0, record_terminator};
      default:          rd_err = 1'b1;
    endcase
  end

  // Read answer one cycle after address taken; talk read clears pending
  wire talk_read = ar_take && (i_araddr == `OFS_RESULT_LO);
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
    end else begin
      o_arready <= ~o_rvalid & ~ar_take;
      if (ar_take) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_mux;
        o_rresp  <= rd_err ? 2'h2 : 2'h0;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Settings update
  // ----------------------------------------------------------------
  wire wr_ctrl  = do_write && aw_addr_r == `OFS_CTRL;
  wire wr_event = do_write && aw_addr_r == `OFS_EVENT;
  wire host_trigger = wr_event && wd[0];                // *TRG or GET
  wire program_msg  = do_write & ~(aw_addr_r == `OFS_CTRL & w_strb_r == 4'h1 & ~wd[1]);
  wire [39:0] ofs_req = {aw_addr_r == `OFS_OFFSET_HI ? wd[7:0] : o_offset_frequency[39:32],
                         aw_addr_r == `OFS_OFFSET_LO ? wd : o_offset_frequency[31:0]};

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      offset_auto_update_r       <= 1'b0;
      offset_active_r            <= 1'b0;
      output_style_r             <= `RST_OUT_STYLE;
      line_ending_select_r       <= 1'b0;
      sample_or_freeze_r         <= 1'b0;
      aggregate_overlap_select_r <= 1'b0;
      aggregate_count_exponent_r <= `RST_COUNT_EXP;
      fast_sampling_enable_r     <= 1'b0;
      fast_sampling_points_r     <= `RST_FAST_POINTS;
      fast_sampling_interval_r   <= `RST_FAST_IVAL;
      o_internal_ref             <= 1'b0;
      o_granularity              <= `RST_GRANULARITY;
      o_pause_code               <= `RST_PAUSE_CODE;
      o_aggregate_function       <= 3'h0;
      o_trigger_source           <= 2'h0;
      o_trigger_polarity         <= 1'b0;
      o_trigger_delay            <= 27'h0;
      o_offset_frequency         <= 40'h00_0000_0000;
    end else begin
      // Program message returns to standard formatting
      if (program_msg) output_style_r <= `STYLE_STD;
      if (wr_ctrl) begin
        if (!program_msg) output_style_r <= wd[1:0];
        line_ending_select_r   <= wd[2];
        o_internal_ref         <= wd[3];
        sample_or_freeze_r     <= wd[4];
        o_trigger_polarity     <= wd[5];
        fast_sampling_enable_r <= wd[6];
        aggregate_overlap_select_r <= wd[7];
        offset_active_r        <= wd[8];
        offset_auto_update_r   <= wd[9];
      end
      if (do_write && aw_addr_r == `OFS_MEAS) begin
        if (wd[3:0] <= `GRAN_MAX) o_granularity <= wd[3:0];
        if (wd[7:4] <= `PAUSE_MAX) o_pause_code <= wd[7:4];
        if (wd[10:8] <= `AGG_MAX) o_aggregate_function <= wd[10:8];
        if (wd[14:12] >= `EXP_MIN && wd[14:12] <= `EXP_MAX)
          aggregate_count_exponent_r <= wd[14:12];
      end
      if (do_write && aw_addr_r == `OFS_TRIG && wd[1:0] <= `TRIG_SRC_MAX)
        o_trigger_source <= wd[1:0];
      if (do_write && aw_addr_r == `OFS_DELAY)
        o_trigger_delay <= (wd > {5'h0, `DLY_MAX_NS}) ? `DLY_MAX_NS : round_delay(wd[26:0]);
      if (do_write && aw_addr_r == `OFS_FAST) begin
        if (valid_points(wd)) fast_sampling_points_r <= wd[11:0];
        else if (wd[31]) fast_sampling_interval_r <= round_interval({1'b0, wd[30:0]});
      end
      // Offset written by host, or replaced by each result
      if (i_result_valid && offset_auto_update_r)
        o_offset_frequency <= i_result_value;
      else if (do_write && (aw_addr_r == `OFS_OFFSET_LO || aw_addr_r == `OFS_OFFSET_HI))
        o_offset_frequency <= (ofs_req > `FMAX_HZ) ? `FMAX_HZ : ofs_req;
    end
  end

  // ----------------------------------------------------------------
  // Result capture and measurement pacing
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pending_r          <= 1'b0;
      latest_value_r     <= 40'h00_0000_0000;
      latest_neg_r       <= 1'b0;
      latest_kind_r      <= 2'h0;
      latest_exp_r       <= 2'h0;
      o_measure_enable   <= 1'b1;
      o_fast_start       <= 1'b0;
      o_aggregate_count  <= 21'h0_000A;
      o_crlf_ending      <= 1'b0;
    end else begin
      // Newest result kept for talk reads
      if (i_result_valid) begin
        latest_value_r <= i_result_value;
        latest_neg_r   <= i_result_negative;
        latest_kind_r  <= i_result_kind;
        latest_exp_r   <= i_result_exp;
      end
      // Result arrival wins over its delivery
      if (i_result_valid) pending_r <= 1'b1;
      else if (talk_read) pending_r <= 1'b0;
      // Hold stops; trigger restarts; sync style waits for delivery
      if (sample_or_freeze_r && !host_trigger)
        o_measure_enable <= 1'b0;
      else if (output_style_r == `STYLE_SYNC)
        o_measure_enable <= ~(pending_r | i_result_valid) | talk_read;
      else
        o_measure_enable <= 1'b1;
      o_fast_start      <= fast_sampling_enable_r & host_trigger;
      o_aggregate_count <= agg_count(aggregate_overlap_select_r,
                                     aggregate_count_exponent_r);
      o_crlf_ending     <= line_ending_select_r;
    end
  end

endmodule

// *** counter_remote_settings_map.vh ***
// Purpose : Register offsets, reset values, limits and codes
// Assumes : Included by counter_remote_settings.v and by the assertion module
// Notes   : One aligned 32-bit word per register
`ifndef COUNTER_REMOTE_SETTINGS_MAP_VH
`define COUNTER_REMOTE_SETTINGS_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_OFFSET_LO   8'h04
`define OFS_OFFSET_HI   8'h08
`define OFS_MEAS        8'h0C
`define OFS_TRIG        8'h10
`define OFS_DELAY       8'h14
`define OFS_FAST        8'h18
`define OFS_STATUS      8'h1C
`define OFS_RESULT_LO   8'h20
`define OFS_RESULT_HI   8'h24
`define OFS_RECORD      8'h28
`define OFS_BASEFREQ_LO 8'h2C
`define OFS_BASEFREQ_HI 8'h30
`define OFS_EVENT       8'h34

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_GRANULARITY 4'h5
`define RST_PAUSE_CODE  4'h6
`define RST_COUNT_EXP   3'h1
`define RST_OUT_STYLE   2'h2
`define RST_FAST_POINTS 12'h7D0
`define RST_FAST_IVAL   11'h3E8

// ----------------------------------------------------------------
// Limits and codes
// ----------------------------------------------------------------
`define FMAX_HZ         40'h09_502F_9000
`define GRAN_MAX        4'h9
`define PAUSE_MAX       4'hC
`define AGG_MAX         3'h4
`define EXP_MIN         3'h1
`define EXP_MAX         3'h6
`define TRIG_SRC_MAX    2'h2
`define STYLE_LEGACY    2'h0
`define STYLE_SYNC      2'h1
`define STYLE_STD       2'h2
`define DLY_OFF_NS      27'h14
`define DLY_STEP1_MAX   27'h140
`define DLY_STEP2_MAX   27'h3E8
`define DLY_MAX_NS      27'h5F5_E100
`define CH_ASCII_F      8'h46
`define CH_ASCII_R      8'h52
`define CH_ASCII_W      8'h57
`define CH_ASCII_P      8'h50
`define CH_ASCII_S      8'h53
`define CH_ASCII_SP     8'h20
`define CH_ASCII_MINUS  8'h2D
`define CH_ASCII_CR     8'h0D
`define CH_ASCII_LF     8'h0A

`endif

// *** crs_props.sv ***
// Purpose : Bus and range assertions for counter_remote_settings
// Assumes : One clock domain, watches top-level ports only
// Notes   : Bound to every instance of the settings block
`timescale 1ns/1ps
`include "counter_remote_settings_map.vh"
module crs_props (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // Register bus
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic [7:0]  i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  // Settings
  input wire logic [3:0]  o_granularity,
  input wire logic [20:0] o_aggregate_count,
  input wire logic [1:0]  o_trigger_source,
  input wire logic [26:0] o_trigger_delay,
  input wire logic [39:0] o_offset_frequency,
  input wire logic        o_fast_start
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  write_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> ##1 o_bvalid)
    else $error("write response late");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  write_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while busy");
  read_busy_a: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while busy");
  bad_addr_a: assert property (i_arvalid && o_arready && i_araddr > 8'h34 |=>
      o_rresp == 2'b10 && o_rdata == 32'h0)
    else $error("unmapped read not refused");

  // ---------------------------------------------------------------
  // Setting ranges
  // ---------------------------------------------------------------
  gran_range_a: assert property (o_granularity <= 4'h9)
    else $error("granularity out of range");
  count_legal_a: assert property (o_aggregate_count inside {21'h0A, 21'h64, 21'h3E8,
      21'h2710, 21'h1_86A0, 21'hF_4240, 21'h2, 21'h4, 21'h8, 21'h10, 21'h20, 21'h40})
    else $error("aggregate count illegal");
  source_range_a: assert property (o_trigger_source <= 2'h2)
    else $error("trigger source illegal");
  delay_step_a: assert property ((o_trigger_delay == 27'h0 || o_trigger_delay > 27'h14)
      && o_trigger_delay <= 27'h5F5_E100)
    else $error("trigger delay illegal");
  fmax_range_a: assert property (o_offset_frequency <= `FMAX_HZ)
    else $error("offset above top frequency");
  fast_pulse_a: assert property (o_fast_start |=> !o_fast_start)
    else $error("fast start longer than a pulse");
endmodule

bind counter_remote_settings crs_props i_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_bresp(o_bresp), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .o_granularity(o_granularity), .o_aggregate_count(o_aggregate_count),
  .o_trigger_source(o_trigger_source), .o_trigger_delay(o_trigger_delay),
  .o_offset_frequency(o_offset_frequency), .o_fast_start(o_fast_start));

// *** meas_core_model.sv ***
// Purpose : Measurement core stand-in that hands results to the block
// Assumes : Same clock as the block
// Notes   : Fields inverted after each pulse
`timescale 1ns/1ps
module meas_core_model (
  // Clock
  input wire logic         i_clk,
  // Result stream
  output logic             o_result_valid,
  output logic [39:0]      o_result_value,
  output logic             o_result_negative,
  output logic [1:0]       o_result_kind,
  output logic [1:0]       o_result_exp
);
  // Idle at time zero
  initial begin
    o_result_valid = 1'b0;
    o_result_value = 40'h0;
    o_result_negative = 1'b0;
    o_result_kind = 2'h0;
    o_result_exp = 2'h0;
  end

  // One-cycle result pulse, then stale fields inverted
  task automatic send(input logic [39:0] v, input logic n, input logic [1:0] k,
                      input logic [1:0] e);
    @(posedge i_clk);
    o_result_valid <= 1'b1;
    o_result_value <= v;
    o_result_negative <= n;
    o_result_kind <= k;
    o_result_exp <= e;
    @(posedge i_clk);
    o_result_valid <= 1'b0;
    o_result_value <= ~v;
    o_result_negative <= ~n;
    o_result_kind <= ~k;
    o_result_exp <= ~e;
  endtask
endmodule

// *** testbench.sv ***
// Purpose : Self-checking bench for counter_remote_settings
// Assumes : AXI4-Lite master tasks; core model supplies results
// Notes   : Expectations come from setting codes and limits
`timescale 1ns/1ps
module testbench;
  logic        i_clk, i_rstn, awvalid, wvalid, bready, arvalid, rready, ch2;
  logic        awready, wready, bvalid, arready, rvalid, rv, neg, meas_en, fast, iref, pol, crlf;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, gran, pause;
  logic [1:0]  bresp, rresp, rs, kind, rexp, src;
  logic [39:0] rval, base, offs;
  logic [2:0]  agg;
  logic [20:0] cnt;
  logic [26:0] dly;
  logic [31:0] dreq [6] = '{32'hF, 32'h12C, 32'h14A, 32'h3E7, 32'h4D2, 32'h8F0_D180};
  logic [26:0] dexp [6] = '{27'h0, 27'h12C, 27'h140, 27'h3C0, 27'h4B0, 27'h5F5_E100};
  logic [7:0]  kch [4] = '{8'h46, 8'h52, 8'h57, 8'h50};
  int          num_errors, checked, fast_seen, i;
  counter_remote_settings i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_result_valid(rv), .i_result_value(rval), .i_result_negative(neg), .i_result_kind(kind),
    .i_result_exp(rexp), .i_base_freq(base), .i_channel_two(ch2), .o_measure_enable(meas_en),
    .o_fast_start(fast), .o_internal_ref(iref), .o_granularity(gran), .o_pause_code(pause),
    .o_aggregate_function(agg), .o_aggregate_count(cnt), .o_trigger_source(src),
    .o_trigger_polarity(pol), .o_trigger_delay(dly), .o_offset_frequency(offs),
    .o_crlf_ending(crlf));
  meas_core_model i_core (
    .i_clk(i_clk), .o_result_valid(rv), .o_result_value(rval), .o_result_negative(neg),
    .o_result_kind(kind), .o_result_exp(rexp));

  // Clock, fast-start counter
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (fast === 1'b1) fast_seen <= fast_seen + 1;

  // ---------------------------------------------------------------
  // Checks, verdict and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rs = bresp;
    @(posedge i_clk);
    if (n == 50) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    int n;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rs = rresp;
    if (n == 50) begin
      num_errors++;
      final_report();
    end
    chk(name, 40'(exp), 40'(rdata));
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {i_rstn, awvalid, wvalid, bready, arvalid, rready, ch2} = 7'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    base = 40'h01_0000_0005;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    chk("reset levels", 40'h01_5600_000A, {meas_en, gran, pause, 3'h0, cnt});
    chk("reset zeros", 40'h0, {agg, src, pol, dly, iref, crlf, fast, offs[3:0]});
    rd("ctrl", 8'h00, 32'h2);
    rd("meas", 8'h0C, 32'h1065);
    rd("fast", 8'h18, 32'h03E8_07D0);
    wr(8'h0C, 32'h6409);
    chk("meas set", 40'h00_128F_4240, {gran, 1'b0, agg, cnt});
    wr(8'h00, 32'hAE);
    chk("overlap", 40'h407, {cnt, 1'b0, iref, pol, crlf});
    rd("ending", 8'h34, 32'hD);
    wr(8'h0C, 32'h700A);
    rd("meas keep", 8'h0C, 32'h6009);
    for (i = 0; i < 4; i++) begin
      wr(8'h10, 32'(i));
      chk("source", 40'(i == 3 ? 2 : i), 40'(src));
    end
    for (i = 0; i < 6; i++) begin
      wr(8'h14, dreq[i]);
      chk("delay", 40'(dexp[i]), 40'(dly));
    end
    wr(8'h18, 32'h64);
    wr(8'h18, 32'h12C);
    wr(8'h18, 32'h8000_02BC);
    rd("fast set", 8'h18, 32'h01F4_0064);
    wr(8'h18, 32'h8000_0007);
    rd("fast min", 8'h18, 32'h000A_0064);
    wr(8'h34, 32'h1);
    wr(8'h00, 32'h42);
    chk("no fast start", 40'h0, 40'(fast_seen));
    wr(8'h34, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("fast start", 40'h1, 40'(fast_seen));
    wr(8'h00, 32'h12);
    rd("hold", 8'h1C, 32'h0);
    wr(8'h00, 32'h102);
    for (i = 0; i < 4; i++) begin
      i_core.send(40'h100 + 40'(i), i[0], i[1:0], i[1:0]);
      rd("record", 8'h28, {kch[i], 8'h53, i[0] ? 8'h2D : 8'h20, 8'h30 + 8'(i)});
    end
    wr(8'h00, 32'h0, 4'h1);
    i_core.send(40'h777, 1'b0, 2'h0, 2'h0);
    rd("record plain", 8'h28, 32'h4620_2030);
    rd("talk", 8'h20, 32'h777);
    rd("style legacy", 8'h00, 32'h0);
    wr(8'h00, 32'h1, 4'h1);
    i_core.send(40'h888, 1'b0, 2'h0, 2'h0);
    repeat (2) @(posedge i_clk);
    rd("pending", 8'h1C, 32'h1);
    rd("talk sync", 8'h20, 32'h888);
    rd("resumed", 8'h1C, 32'h4);
    wr(8'h10, 32'h0);
    rd("style back", 8'h00, 32'h2);
    wr(8'h04, 32'hFFFF_FFFF);
    wr(8'h08, 32'hFF);
    chk("offset clamp", 40'h09_502F_9000, offs);
    rd("offset lo", 8'h04, 32'h502F_9000);
    wr(8'h00, 32'h202);
    i_core.send(40'h01_2345_6789, 1'b0, 2'h0, 2'h0);
    repeat (2) @(posedge i_clk);
    chk("auto offset", 40'h01_2345_6789, offs);
    rd("base lo", 8'h2C, 32'h5);
    rd("base hi", 8'h30, 32'h1);
    ch2 <= 1'b1;
    rd("base ch2", 8'h2C, 32'h0);
    rd("unmapped", 8'h40, 32'h0);
    chk("rresp", 40'h2, 40'(rs));
    wr(8'h40, 32'h1);
    chk("bresp", 40'h2, 40'(rs));
    final_report();
  end
endmodule
